// ### core/transceiver_host_mode_status.sv
// module: host pin decoding, mode control, fault output and status word readout
// What this block does
// - pins decode: both high normal, standby only receive-only, mode only sleep, none standby.
// - go-to-sleep command passes automatically into sleep mode.
// - absent io reference forces fault output low and pins to defaults.
// - io undervoltage ignores host commands and forces sleep mode.
// - pin levels must be stable for filter time before a mode change.
// - mode change completes within mode change time; outputs valid afterwards.
// - inputs level triggered; mode pins pass an extra digital filter.
// - the mode select pin also triggers serial readout of the status word.
// - in normal mode only, bus versus transmit mismatch records bus failure.
// - a detected bus failure is reported on the fault output in normal mode and in receive-only with no wake pending.
// - io undervoltage forces the fault output low; battery and core undervoltage show only in normal mode and in receive-only with no wake pending.
// - wake detection stays active in every mode.
// - failure, wake and diagnostic data kept in one sixteen bit status word.
// - bit0 local wake, bit1 remote wake, bit2 reserved inactive, bit3 power-up.
// - bits 4-10 error causes in order, summarised in bit 11.
// - bit12 wake source, bits 13/14 pin indications, bit15 even parity.
// - every status bit except the bit15 parity is active low.
// - once readout enabled, each mode pin falling edge shifts next bit, lsb first.
// - latched bits clear after normal entry and full read, only if cause gone.
module transceiver_host_mode_status
  import host_status_pkg::*;
#(
  parameter int FILTER_COUNT = FILTER_CYCLES,
  parameter int MODE_CHANGE_COUNT = MODE_CHANGE_CYCLES,
  parameter int TIMEOUT_COUNT = READOUT_TIMEOUT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic standby_select_n,
  input wire logic mode_select,
  input wire logic io_reference_supply,
  input wire logic battery_uv,
  input wire logic core_uv,
  input wire logic local_wake,
  input wire logic remote_wake,
  input wire logic overtemp_err,
  input wire logic overtemp_warn,
  input wire logic tx_timeout,
  input wire logic tx_active,
  input wire logic tx_data,
  input wire logic rx_data,
  output logic fault_status_n,
  output host_status_pkg::op_mode_type op_mode,
  output logic mode_valid,
  output logic [15:0] status_word
);
  import host_status_pkg::*;

  // ----------------------------------------
  // input gating and filtering
  // ----------------------------------------
  // pin defaults when supply absent
  // a missing io reference reads both pins low, so they look like a standby command
  wire io_ok = io_reference_supply;
  wire stby_in = io_ok ? standby_select_n : 1'b0;
  wire mode_in = io_ok ? mode_select : 1'b0;

  // glitch stage, previous sample and accepted level of each pin
  logic stby_glitch_q;
  logic mode_glitch_q;
  logic stby_f_q;
  logic mode_f_q;
  logic stby_prev_q;
  logic mode_prev_q;
  // limitation: filter counts above 65536 cycles do not fit this counter
  logic [15:0] filt_cnt_q;
  logic [15:0] filt_cnt_d;

  wire pins_moved = (stby_glitch_q != stby_prev_q) || (mode_glitch_q != mode_prev_q);
  wire filt_done = (filt_cnt_q >= 16'(FILTER_COUNT - 1));
  // accept only stable levels
  // both pins share one counter, so a change on either restarts the wait for both
  wire pins_accept = !pins_moved && filt_done &&
                     ((stby_glitch_q != stby_f_q) || (mode_glitch_q != mode_f_q));
  always_comb begin
    filt_cnt_d = filt_cnt_q;
    if (pins_moved) begin
      filt_cnt_d = 16'h0000;
    end else if (!filt_done) begin
      filt_cnt_d = filt_cnt_q + 16'h0001;
    end
  end

  // filter registers; restart on any level change so short pulses never pass
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stby_glitch_q <= 1'b0;
      mode_glitch_q <= 1'b0;
      stby_prev_q <= 1'b0;
      mode_prev_q <= 1'b0;
      stby_f_q <= 1'b0;
      mode_f_q <= 1'b0;
      filt_cnt_q <= 16'h0000;
    end else begin
      stby_glitch_q <= stby_in;
      mode_glitch_q <= mode_in;
      // prev trails the glitch stage by one cycle; a difference means the pins moved
      stby_prev_q <= stby_glitch_q;
      mode_prev_q <= mode_glitch_q;
      filt_cnt_q <= filt_cnt_d;
      if (pins_accept) begin
        stby_f_q <= stby_glitch_q;
        mode_f_q <= mode_glitch_q;
      end
    end
  end

  // ----------------------------------------
  // readout sequencer
  // ----------------------------------------
  logic mode_f_prev_q;
  // armed after the first edge, enabled once the word may be shifted out
  logic rd_armed_q;
  logic rd_enabled_q;
  logic [1:0] rd_edges_q;
  logic [3:0] rd_index_q;
  logic rd_bit_q;
  logic [15:0] rd_timer_q;
  logic rd_wrapped_q;
  op_mode_type mode_q, mode_d;

  wire mode_rise = mode_f_q && !mode_f_prev_q;
  wire mode_fall = !mode_f_q && mode_f_prev_q;
  wire mode_edge = mode_rise || mode_fall;
  wire rd_allowed = io_ok && (mode_q == normal_mode || mode_q == receive_only_mode ||
                    mode_q == standby_mode);
  wire rd_active = rd_armed_q || rd_enabled_q;
  // an idle readout ends on timeout and lets a held-off mode change through
  wire rd_timeout = rd_active && (rd_timer_q >= 16'(TIMEOUT_COUNT - 1)) && !mode_edge;
  // edges needed after the starting edge before the word is enabled
  wire [1:0] edges_needed = (mode_q == normal_mode) ? 2'd1 : 2'd2;
  wire full_read = rd_enabled_q && mode_fall && (rd_index_q == BIT_INDEX_LAST);

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  logic [15:0] latch_q;
  logic wake_src_q;
  logic clear_pending_q;
  logic [15:0] cause;
  logic [15:0] set_word;

  // mismatch only counts in normal mode
  // sampled every cycle, so a single disagreeing cycle is enough to latch the bit
  wire bus_fail = (mode_q == normal_mode) && tx_active && (tx_data != rx_data);
  always_comb begin
    cause = 16'h0000;
    // wake causes watched in every mode
    cause[BIT_LOCAL_WAKE] = local_wake;
    cause[BIT_REMOTE_WAKE] = remote_wake;
    cause[BIT_BUS_ERR] = bus_fail;
    cause[BIT_OVERTEMP_ERR] = overtemp_err;
    cause[BIT_OVERTEMP_WARN] = overtemp_warn;
    cause[BIT_TX_TIMEOUT] = tx_timeout;
    cause[BIT_BAT_UV] = battery_uv;
    cause[BIT_CORE_UV] = core_uv;
    cause[BIT_IO_UV] = !io_ok;
  end

  always_comb begin
    set_word = latch_q;
    set_word[BIT_RESERVED] = 1'b0;
    set_word[BIT_ERROR_SUM] = |latch_q[LATCH_LAST:LATCH_FIRST];
    set_word[BIT_WAKE_SOURCE] = wake_src_q;
    set_word[BIT_MODE_IND] = mode_f_q;
    set_word[BIT_STBY_IND] = stby_f_q;
    set_word[BIT_PARITY] = 1'b0;
  end
  // active low image of set bits
  wire [14:0] low_bits = ~set_word[14:0];
  // even parity over the full word
  // parity is taken on the active-low image, which is what the host reads
  assign status_word = {^low_bits, low_bits};

  // latched bits; set beats clear so an event in the clearing cycle survives
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      latch_q <= 16'h0008;
      wake_src_q <= 1'b0;
    end else begin
      // clear only causes that are gone
      // the power-up bit has no live cause, so the first clearing read removes it
      if (clear_pending_q && full_read) begin
        latch_q <= (latch_q & cause) | cause;
      end else begin
        latch_q <= latch_q | cause;
      end
      // source follows the latest event; local wins when both arrive together
      if (local_wake) begin
        wake_src_q <= 1'b1;
      end else if (remote_wake) begin
        wake_src_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // operating mode control
  // ----------------------------------------
  logic [15:0] change_cnt_q;
  logic mode_start;
  op_mode_type target;

  always_comb begin
    unique case ({stby_f_q, mode_f_q})
      2'b11: target = normal_mode;
      2'b10: target = receive_only_mode;
      2'b01: target = go_to_sleep_command;
      2'b00: target = standby_mode;
    endcase
  end

  // sleep stays put while the pins still ask for go-to-sleep
  always_comb begin
    mode_d = mode_q;
    mode_start = 1'b0;
    if (!io_ok) begin
      mode_d = sleep_mode;
    end else if (mode_q == go_to_sleep_command) begin
      mode_d = sleep_mode;
    end else if (!rd_active && target != mode_q &&
                 !(mode_q == sleep_mode && target == go_to_sleep_command)) begin
      // mode changes are held off while a readout runs
      mode_d = target;
    end
    mode_start = (mode_d != mode_q);
  end

  // outputs marked valid after mode change time
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= standby_mode;
      change_cnt_q <= 16'h0000;
      clear_pending_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (mode_start) begin
        change_cnt_q <= 16'(MODE_CHANGE_COUNT);
      end else if (change_cnt_q != 16'h0000) begin
        change_cnt_q <= change_cnt_q - 16'h0001;
      end
      // clearing is armed only by a real entry into normal mode, not by staying there
      if (mode_start && mode_d == normal_mode) begin
        clear_pending_q <= 1'b1;
      end else if (full_read || mode_d != normal_mode) begin
        clear_pending_q <= 1'b0;
      end
    end
  end
  assign op_mode = mode_q;
  assign mode_valid = (change_cnt_q == 16'h0000);

  // ----------------------------------------
  // readout state
  // ----------------------------------------
  // mode pin edges arm the readout
  // edges are seen after filtering, so the readout clock must be slower than the filter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_f_prev_q <= 1'b0;
      rd_armed_q <= 1'b0;
      rd_enabled_q <= 1'b0;
      rd_edges_q <= 2'd0;
      rd_index_q <= 4'h0;
      rd_bit_q <= 1'b1;
      rd_timer_q <= 16'h0000;
      rd_wrapped_q <= 1'b0;
    end else begin
      mode_f_prev_q <= mode_f_q;
      // timer restarts on every filtered edge; a stopped clock ends the readout
      if (mode_edge || !rd_active) begin
        rd_timer_q <= 16'h0000;
      end else begin
        rd_timer_q <= rd_timer_q + 16'h0001;
      end
      // leaving the allowed modes or timing out drops the readout at once
      if (!rd_allowed || rd_timeout) begin
        rd_armed_q <= 1'b0;
        rd_enabled_q <= 1'b0;
        rd_wrapped_q <= 1'b0;
      // first edge arms; normal needs one more edge, the other modes two
      end else if (!rd_active && mode_edge) begin
        rd_armed_q <= 1'b1;
        rd_edges_q <= 2'd0;
      end else if (rd_armed_q && mode_edge) begin
        if (rd_edges_q + 2'd1 == edges_needed) begin
          rd_armed_q <= 1'b0;
          rd_enabled_q <= 1'b1;
          rd_index_q <= 4'h0;
        end
        rd_edges_q <= rd_edges_q + 2'd1;
      end else if (rd_enabled_q && mode_fall) begin
        // lsb first, wraps after bit 15
        rd_bit_q <= status_word[rd_index_q];
        rd_index_q <= rd_index_q + 4'h1;
        if (rd_index_q == BIT_INDEX_LAST) begin
          rd_wrapped_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // fault output
  // ----------------------------------------
  // bus failure and error summary on fault output
  wire err_flag = set_word[BIT_ERROR_SUM];
  wire wake_flag = set_word[BIT_LOCAL_WAKE] | set_word[BIT_REMOTE_WAKE];
  logic status_pin;
  // outside readout the pin shows the summary chosen by the current mode
  always_comb begin
    unique case (mode_q)
      normal_mode: status_pin = !err_flag;
      receive_only_mode: status_pin = wake_flag ? wake_src_q : !err_flag;
      default: status_pin = !wake_flag;
    endcase
  end

  // low whenever io reference missing
  // registered so the pin never glitches while mode or status word settle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fault_status_n <= 1'b0;
    end else if (!io_ok) begin
      fault_status_n <= 1'b0;
    end else if (rd_enabled_q) begin
      fault_status_n <= rd_bit_q;
    end else begin
      fault_status_n <= status_pin;
    end
  end

endmodule

// ### core/host_status_pkg.sv
// package: constants and types for the transceiver host-mode and status block
package host_status_pkg;

  // ----------------------------------------
  // status word layout
  // ----------------------------------------
  localparam int STATUS_WIDTH = 16;
  localparam int BIT_LOCAL_WAKE = 0;
  localparam int BIT_REMOTE_WAKE = 1;
  localparam int BIT_RESERVED = 2;
  localparam int BIT_POWER_UP = 3;
  localparam int BIT_BUS_ERR = 4;
  localparam int BIT_OVERTEMP_ERR = 5;
  localparam int BIT_OVERTEMP_WARN = 6;
  localparam int BIT_TX_TIMEOUT = 7;
  localparam int BIT_BAT_UV = 8;
  localparam int BIT_CORE_UV = 9;
  localparam int BIT_IO_UV = 10;
  localparam int BIT_ERROR_SUM = 11;
  localparam int BIT_WAKE_SOURCE = 12;
  localparam int BIT_MODE_IND = 13;
  localparam int BIT_STBY_IND = 14;
  localparam int BIT_PARITY = 15;
  localparam int LATCH_FIRST = 4;
  localparam int LATCH_LAST = 10;
  localparam logic [15:0] STATUS_RESET = 16'hffff;
  localparam logic [3:0] BIT_INDEX_LAST = 4'hf;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MODE_PIN_FILTER_TIME_NS = 2000;
  localparam int MODE_CHANGE_TIME_NS = 10000;
  localparam int READOUT_TIMEOUT_NS = 20000;
  localparam int FILTER_CYCLES = (MODE_PIN_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_CHANGE_CYCLES = MODE_CHANGE_TIME_NS / CLK_PERIOD_NS;
  localparam int READOUT_TIMEOUT_CYCLES = READOUT_TIMEOUT_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    standby_mode,
    normal_mode,
    receive_only_mode,
    go_to_sleep_command,
    sleep_mode
  } op_mode_type;

endpackage

// ### dv/host_mode_checker.sv
// checker: mode, fault and status relations seen at the block's ports
module host_mode_checker
  import host_status_pkg::*;
#(
  parameter int FILTER_COUNT = FILTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic standby_select_n,
  input wire logic mode_select,
  input wire logic io_reference_supply,
  input wire logic fault_status_n,
  input wire host_status_pkg::op_mode_type op_mode,
  input wire logic mode_valid,
  input wire logic [15:0] status_word
);
  localparam int SLEEP_WAIT = 40;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // io loss fault
  chk_io_fault_low: assert property (!io_reference_supply [*4] |-> !fault_status_n)
    else $error("fault output high without io reference");
  chk_io_forces_sleep: assert property (!io_reference_supply [*8] |-> op_mode == sleep_mode)
    else $error("mode not sleep without io reference");
  chk_reserved_high: assert property (status_word[2] == 1'b1)
    else $error("reserved status bit set");
  chk_parity_even: assert property (^status_word == 1'b0)
    else $error("status word parity odd");
  chk_error_sum: assert property (status_word[11] == (&status_word[10:4]))
    else $error("error summary disagrees with causes");
  // filtered normal entry: pins must have been high a filter time ago
  chk_normal_filtered: assert property ($changed(op_mode) && op_mode == normal_mode
    |-> $past(standby_select_n && mode_select, FILTER_COUNT))
    else $error("normal entered without stable pins");
  chk_sleep_follows: assert property (op_mode == go_to_sleep_command
    |-> ##[1:SLEEP_WAIT] op_mode == sleep_mode)
    else $error("go to sleep did not reach sleep");
  chk_valid_drops: assert property ($changed(op_mode) |-> ##[0:1] !mode_valid)
    else $error("mode valid stayed high over change");
  chk_valid_held: assert property ($fell(mode_valid) |-> !mode_valid [*7])
    else $error("mode valid returned too early");
endmodule

// ### dv/host_pin_model.sv
// host controller model: drives the two mode pins and clocks status readout
module host_pin_model #(
  parameter int FILTER_COUNT = 4
) (
  input wire logic sys_clk,
  output logic standby_select_n,
  output logic mode_select
);
  initial begin
    standby_select_n = 1'b0;
    mode_select = 1'b0;
  end
  task automatic command(input logic stby, input logic mode, input int hold);
    @(negedge sys_clk);
    standby_select_n = stby;
    mode_select = mode;
    repeat (hold) @(negedge sys_clk);
  endtask
  // readout clock edge, phase well past the filter delay
  task automatic clock_edge(input logic lvl);
    @(negedge sys_clk);
    mode_select = lvl;
    repeat (4 * FILTER_COUNT) @(negedge sys_clk);
  endtask
endmodule

// ### dv/transceiver_host_mode_status_tb_top.sv
// testbench: mode decoding, filtering, supply loss and status readout
module transceiver_host_mode_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import host_status_pkg::*;
  localparam int FILT = 4;
  localparam int MCHG = 8;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic standby_select_n;
  logic mode_select;
  logic io_reference_supply = 1'b1;
  logic [4:0] causes = 5'h00;
  logic local_wake = 1'b0;
  logic remote_wake = 1'b0;
  logic tx_active = 1'b0;
  logic tx_data = 1'b0;
  logic rx_data = 1'b0;
  logic fault_status_n;
  op_mode_type op_mode;
  logic mode_valid;
  logic [15:0] status_word;
  int errors = 0;
  int n_tests = 0;
  // short counts keep the run small
  transceiver_host_mode_status #(.FILTER_COUNT(FILT), .MODE_CHANGE_COUNT(MCHG),
    .TIMEOUT_COUNT(40)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .standby_select_n(standby_select_n),
    .mode_select(mode_select), .io_reference_supply(io_reference_supply),
    .battery_uv(causes[3]), .core_uv(causes[4]), .local_wake(local_wake),
    .remote_wake(remote_wake), .overtemp_err(causes[0]), .overtemp_warn(causes[1]),
    .tx_timeout(causes[2]), .tx_active(tx_active), .tx_data(tx_data), .rx_data(rx_data),
    .fault_status_n(fault_status_n), .op_mode(op_mode), .mode_valid(mode_valid),
    .status_word(status_word)
  );
  host_pin_model #(.FILTER_COUNT(FILT)) i_host (
    .sys_clk(sys_clk), .standby_select_n(standby_select_n), .mode_select(mode_select)
  );
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // bounded wait, then judge the decoded mode
  task automatic go(input logic s, input logic m, input op_mode_type e);
    int n;
    n = 0;
    i_host.command(s, m, 1);
    while (op_mode !== e && n < 300) begin
      idle(1);
      n++;
    end
    check(op_mode, e);
    check(mode_valid, 1'b0);
    idle(MCHG - 1);
    check(mode_valid, 1'b0);
    idle(1);
    check(mode_valid, 1'b1);
  endtask
  // transmit against receive disagreement
  task automatic mismatch;
    tx_active = 1'b1;
    tx_data = 1'b1;
    rx_data = 1'b1;
    idle(10);
    rx_data = 1'b0;
    idle(10);
    tx_active = 1'b0;
    tx_data = 1'b0;
    idle(10);
  endtask
  task automatic glitch;
    i_host.command(1'b1, 1'b1, FILT - 1);
    i_host.command(1'b0, 1'b0, 100);
    check(op_mode, standby_mode);
  endtask
  // two full passes: second one shows the power-up bit cleared
  task automatic read_status;
    logic [15:0] w;
    i_host.clock_edge(1'b0);
    i_host.clock_edge(1'b1);
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 16; b++) begin
        i_host.clock_edge(1'b0);
        w[b] = fault_status_n;
        i_host.clock_edge(1'b1);
      end
      check(w[11:0], (p == 0) ? 12'hff7 : 12'hfff);
      check(^w, 1'b0);
    end
    idle(60);
  endtask
  task automatic error_causes;
    causes = 5'h1f;
    idle(20);
    causes = 5'h00;
    idle(20);
    check(status_word[11:4], 8'h41);
    check(fault_status_n, 1'b0);
    check(status_word[14:13], 2'h0);
    mismatch;
    check(status_word[4], 1'b0);
    remote_wake = 1'b1;
    idle(10);
    remote_wake = 1'b0;
    idle(10);
    check({status_word[12], status_word[1]}, 2'h2);
    local_wake = 1'b1;
    idle(10);
    local_wake = 1'b0;
    idle(10);
    check({status_word[12], status_word[0]}, 2'h0);
  endtask
  task automatic io_loss;
    io_reference_supply = 1'b0;
    idle(20);
    check(fault_status_n, 1'b0);
    check(op_mode, sleep_mode);
    io_reference_supply = 1'b1;
    idle(20);
    check(status_word[10], 1'b0);
  endtask
  initial begin
    idle(8);
    reset = 1'b0;
    check(status_word[3], 1'b0);
    glitch;
    go(1'b1, 1'b0, receive_only_mode);
    mismatch;
    check(status_word[4], 1'b1);
    go(1'b1, 1'b1, normal_mode);
    read_status;
    error_causes;
    go(1'b0, 1'b0, standby_mode);
    go(1'b0, 1'b1, sleep_mode);
    io_loss;
    end_of_test;
  end
  // hang guard, far beyond the expected run of under two thousand cycles
  initial begin
    #(8 * 30000);
    errors++;
    end_of_test;
  end
endmodule
bind transceiver_host_mode_status host_mode_checker #(.FILTER_COUNT(FILTER_COUNT)) i_chk (
  .sys_clk(sys_clk), .reset(reset), .standby_select_n(standby_select_n),
  .mode_select(mode_select), .io_reference_supply(io_reference_supply),
  .fault_status_n(fault_status_n), .op_mode(op_mode), .mode_valid(mode_valid),
  .status_word(status_word)
);
